/* File: ccs_config_slave.sv */
// Serial configuration slave of the clock generator with an APB side door
`timescale 1ns/1ps

// How it works
// R1 - Answer at 110111 plus address-select pin
// R2 - Slave only: never drives clock, starts, stops
// R3 - Every configuration byte readable and writable
// R4 - Block reads and writes of consecutive bytes
// R5 - First written byte sets register pointer
// R6 - Pointer steps by one after each byte
// R7 - All bytes shifted most significant first
// R8 - Stop after any whole byte, partial dropped
// R9 - Master should stop after byte 23
// R10 - Block write acks address, pointer, data
// R11 - Block read via repeated start, master acks
// R12 - Select pins pick one of four sets
// R13 - Frequency follows select pins or writes
// R14 - Output style and state changeable by writes
// R15 - Enable bit 0 tristates, 1 activates output
// R16 - Style bit 1 LVDS, 0 LVPECL
// R17 - Bypass bit 1 skips PLL, 0 uses it
// R18 - Foreign address: no ack, ignore transfer
module ccs_config_slave #(
  parameter logic [ccs_pkg::NUM_REGS*8-1:0] DEFAULT_REGS = 192'h0  // Power-up byte image
) (
  input  wire logic                                 clock,
  input  wire logic                                 srst,
  input  wire logic                                 scl_in,
  input  wire logic                                 serial_data_pin_in,
  output logic                                      serial_data_pin_out,
  output logic                                      serial_data_pin_oe,
  input  wire logic                                 addr_sel,
  input  wire logic [1:0]                           config_set_select,
  output logic [ccs_pkg::NUM_OUTS-1:0]              output_enable_bit,
  output logic [ccs_pkg::NUM_OUTS-1:0]              output_style_bit,
  output logic                                      pll_bypass_bit,
  output logic [ccs_pkg::FREQ_W-1:0]                freq_word,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [ccs_pkg::PADDR_W-1:0]          paddr,
  input  wire logic [31:0]                          pwdata,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Byte at a pointer; positions past the last read as zero
  function automatic logic [7:0] rd_byte(input logic [ccs_pkg::NUM_REGS*8-1:0] img,
                                         input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (p < ccs_pkg::NUM_REGS_B) begin
      v = img[p*8 +: 8];
    end
    return v;
  endfunction

  // True when the APB address is word-aligned and falls inside the byte window
  function automatic logic in_window(input logic [ccs_pkg::PADDR_W-1:0] a);
    return (a >= ccs_pkg::OFF_REGWIN) && (a < ccs_pkg::OFF_REGEND) && (a[1:0] == 2'h0);
  endfunction

  // Byte index for a window address
  function automatic logic [7:0] win_index(input logic [ccs_pkg::PADDR_W-1:0] a);
    logic [ccs_pkg::PADDR_W-1:0] d;
    d = a - ccs_pkg::OFF_REGWIN;
    return d[9:2];
  endfunction

  // True for any address that answers without error
  function automatic logic is_mapped(input logic [ccs_pkg::PADDR_W-1:0] a);
    return (a == ccs_pkg::OFF_CTRL) || (a == ccs_pkg::OFF_STATUS) ||
           (a == ccs_pkg::OFF_WRCNT) || in_window(a);
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  ccs_pkg::ccs_regs_t r_reg;   // Registered state
  ccs_pkg::ccs_regs_t r_next;  // Next state

  // Synced pin levels, taken from second flops only
  logic scl_s;        // Clock level
  logic sda_s;        // Data level
  logic scl_rise;     // Clock rising edge seen
  logic scl_fall;     // Clock falling edge seen
  logic bus_start;    // Start or repeated start
  logic bus_stop;     // Stop condition
  logic [1:0] sel_s;  // Synced set select

  assign scl_s     = r_reg.scl_sync[1];
  assign sda_s     = r_reg.sda_sync[1];
  assign sel_s     = {r_reg.sel1_sync[1], r_reg.sel0_sync[1]};
  assign scl_rise  = scl_s & ~r_reg.scl_prev;
  assign scl_fall  = ~scl_s & r_reg.scl_prev;
  // Data moving while clock stays high marks a frame edge
  assign bus_start = scl_s & r_reg.scl_prev & ~sda_s & r_reg.sda_prev;
  assign bus_stop  = scl_s & r_reg.scl_prev & sda_s & ~r_reg.sda_prev;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // One process computes every next value; link writes come last and win
  always_comb begin
    logic [7:0] wi;
    logic [7:0] nb;
    logic       shifting;
    wi       = 8'h00;
    nb       = 8'h00;
    shifting = 1'b0;
    r_next   = r_reg;

    // Two flops per pin; the first is read only by the second
    r_next.scl_sync  = {r_reg.scl_sync[0], scl_in};
    r_next.sda_sync  = {r_reg.sda_sync[0], serial_data_pin_in};
    r_next.asel_sync = {r_reg.asel_sync[0], addr_sel};
    r_next.sel0_sync = {r_reg.sel0_sync[0], config_set_select[0]};
    r_next.sel1_sync = {r_reg.sel1_sync[0], config_set_select[1]};
    r_next.scl_prev  = scl_s;
    r_next.sda_prev  = sda_s;

    // APB setup phase: latch read data and error for the access phase
    if (psel && !penable) begin
      r_next.prdata  = 32'h0000_0000;
      r_next.pslverr = ~is_mapped(paddr);
      if (paddr == ccs_pkg::OFF_CTRL) begin
        r_next.prdata[ccs_pkg::CTRL_EN_BIT] = r_reg.enable;
      end else if (paddr == ccs_pkg::OFF_STATUS) begin
        r_next.prdata[ccs_pkg::ST_BUSY_BIT]        = (r_reg.state != ccs_pkg::ST_IDLE);
        r_next.prdata[ccs_pkg::ST_RW_BIT]          = r_reg.rw;
        r_next.prdata[ccs_pkg::ST_PTR_LSB +: 8]    = r_reg.ptr;
        r_next.prdata[ccs_pkg::ST_SEL_LSB +: 2]    = sel_s;
      end else if (paddr == ccs_pkg::OFF_WRCNT) begin
        r_next.prdata[15:0] = r_reg.wrcnt;
      end else if (in_window(paddr)) begin
        r_next.prdata[7:0] = rd_byte(r_reg.regs, win_index(paddr));  // R3
      end
    end

    // APB access phase write; read-only words ignore writes
    if (psel && penable && pwrite) begin
      if (paddr == ccs_pkg::OFF_CTRL) begin
        r_next.enable = pwdata[ccs_pkg::CTRL_EN_BIT];
      end else if (in_window(paddr)) begin
        wi = win_index(paddr);
        r_next.regs[wi*8 +: 8] = pwdata[7:0];
      end
    end

    // Receive shifting in address, pointer and write data phases
    shifting = (r_reg.state == ccs_pkg::ST_ADDR) || (r_reg.state == ccs_pkg::ST_PTR) ||
               (r_reg.state == ccs_pkg::ST_WDATA);
    if (shifting && scl_rise && !r_reg.byte_done) begin
      r_next.shreg  = {r_reg.shreg[6:0], sda_s};  // R7
      r_next.bitcnt = r_reg.bitcnt + 4'h1;
      if (r_reg.bitcnt == ccs_pkg::LAST_BIT) begin
        r_next.byte_done = 1'b1;
      end
    end

    // Frame edges override any phase; a cut byte is simply dropped
    if (bus_start) begin
      r_next.state     = ccs_pkg::ST_ADDR;  // R11
      r_next.bitcnt    = 4'h0;
      r_next.byte_done = 1'b0;
      r_next.sda_oe    = 1'b0;
    end else if (bus_stop) begin
      r_next.state     = ccs_pkg::ST_IDLE;  // R8
      r_next.bitcnt    = 4'h0;
      r_next.byte_done = 1'b0;
      r_next.sda_oe    = 1'b0;
    end else begin
      case (r_reg.state)
        // Waiting for a start
        ccs_pkg::ST_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        // Address byte, compared once all eight bits are in
        ccs_pkg::ST_ADDR: begin
          if (scl_fall && r_reg.byte_done) begin
            r_next.byte_done = 1'b0;
            r_next.bitcnt    = 4'h0;
            if (r_reg.enable &&
                r_reg.shreg[7:1] == {ccs_pkg::SLAVE_ADDR_UPPER, r_reg.asel_sync[1]}) begin  // R1
              r_next.rw     = r_reg.shreg[0];
              r_next.sda_oe = 1'b1;  // R10
              r_next.state  = ccs_pkg::ST_ADDR_ACK;
            end else begin
              r_next.state  = ccs_pkg::ST_IGNORE;  // R18
            end
          end
        end
        // Address ack; on read the first data bit goes out here
        ccs_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (r_reg.rw) begin
              nb             = rd_byte(r_reg.regs, r_reg.ptr);  // R11
              r_next.txbyte  = nb;
              r_next.sda_oe  = ~nb[7];  // R7
              r_next.bitcnt  = ccs_pkg::FIRST_TX_BIT;
              r_next.state   = ccs_pkg::ST_RDATA;
            end else begin
              r_next.sda_oe  = 1'b0;
              r_next.state   = ccs_pkg::ST_PTR;
            end
          end
        end
        // Pointer byte
        ccs_pkg::ST_PTR: begin
          if (scl_fall && r_reg.byte_done) begin
            r_next.ptr       = r_reg.shreg;  // R5
            r_next.byte_done = 1'b0;
            r_next.bitcnt    = 4'h0;
            r_next.sda_oe    = 1'b1;  // R10
            r_next.state     = ccs_pkg::ST_PTR_ACK;
          end
        end
        // Pointer ack
        ccs_pkg::ST_PTR_ACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.state  = ccs_pkg::ST_WDATA;
          end
        end
        // Write data; only a whole byte reaches the image
        ccs_pkg::ST_WDATA: begin
          if (scl_fall && r_reg.byte_done) begin
            if (r_reg.ptr < ccs_pkg::NUM_REGS_B) begin
              r_next.regs[r_reg.ptr*8 +: 8] = r_reg.shreg;  // R8 R14
            end
            r_next.wrcnt     = r_reg.wrcnt + 16'h0001;
            r_next.ptr       = r_reg.ptr + 8'h01;  // R6
            r_next.byte_done = 1'b0;
            r_next.bitcnt    = 4'h0;
            r_next.sda_oe    = 1'b1;  // R10
            r_next.state     = ccs_pkg::ST_WDATA_ACK;
          end
        end
        // Data ack, then back for the next byte
        ccs_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.state  = ccs_pkg::ST_WDATA;  // R4
          end
        end
        // Read data, one bit per clock fall, released after bit 0
        ccs_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (r_reg.bitcnt == ccs_pkg::BITS_PER_BYTE) begin
              r_next.sda_oe = 1'b0;
              r_next.state  = ccs_pkg::ST_RACK;
            end else begin
              r_next.sda_oe = ~r_reg.txbyte[6];  // R7
              r_next.txbyte = {r_reg.txbyte[6:0], 1'b0};
              r_next.bitcnt = r_reg.bitcnt + 4'h1;
            end
          end
        end
        // Master ack slot: ack continues the block, nack ends it
        ccs_pkg::ST_RACK: begin
          if (scl_rise) begin
            r_next.ptr = r_reg.ptr + 8'h01;  // R6
            if (sda_s) begin
              r_next.state = ccs_pkg::ST_IGNORE;  // R11
            end else begin
              r_next.byte_done = 1'b1;
            end
          end else if (scl_fall && r_reg.byte_done) begin
            nb               = rd_byte(r_reg.regs, r_reg.ptr);  // R4
            r_next.txbyte    = nb;
            r_next.sda_oe    = ~nb[7];
            r_next.bitcnt    = ccs_pkg::FIRST_TX_BIT;
            r_next.byte_done = 1'b0;
            r_next.state     = ccs_pkg::ST_RDATA;
          end
        end
        // Not addressed or done: stay off the line until a frame edge
        ccs_pkg::ST_IGNORE: begin
          r_next.sda_oe = 1'b0;  // R18
        end
        default: begin
          r_next.state  = ccs_pkg::ST_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end

    // Active set drives the outputs
    r_next.bypass    = r_reg.regs[(ccs_pkg::BYP_BASE + sel_s)*8 + ccs_pkg::BYP_BIT];        // R12 R17
    r_next.out_en    = r_reg.regs[(ccs_pkg::OE_BASE + sel_s)*8 +: ccs_pkg::NUM_OUTS];      // R12 R15
    r_next.out_style = r_reg.regs[(ccs_pkg::STYLE_BASE + sel_s)*8 +: ccs_pkg::NUM_OUTS];   // R12 R16
    r_next.freq      = r_reg.regs[(ccs_pkg::FREQ_BASE + ccs_pkg::FREQ_BYTES*sel_s)*8 +:
                                  ccs_pkg::FREQ_W];                                         // R13
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // Synchronous reset loads the power-up image and an idle link
  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg           <= '0;
      r_reg.scl_sync  <= 2'h3;  // Lines idle high, no false start
      r_reg.sda_sync  <= 2'h3;
      r_reg.scl_prev  <= 1'b1;
      r_reg.sda_prev  <= 1'b1;
      r_reg.state     <= ccs_pkg::ST_IDLE;
      r_reg.ptr       <= 8'h00;
      r_reg.regs      <= DEFAULT_REGS;
      r_reg.enable    <= ccs_pkg::CTRL_EN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Open drain: only ever pulls low; clock pin is input only
  assign serial_data_pin_out = 1'b0;          // R2
  assign serial_data_pin_oe  = r_reg.sda_oe;  // R2
  assign output_enable_bit   = r_reg.out_en;
  assign output_style_bit    = r_reg.out_style;
  assign pll_bypass_bit      = r_reg.bypass;
  assign freq_word           = r_reg.freq;
  assign prdata              = r_reg.prdata;
  assign pslverr             = r_reg.pslverr & psel & penable;
  // Every access completes in its first access cycle
  assign pready              = 1'b1;

endmodule

/* File: ccs_pkg.sv */
// Shared constants, state encoding and the register image of the clock config slave
package ccs_pkg;

  // ---------------------------------------------------------------------------
  // Serial link constants
  // ---------------------------------------------------------------------------
  localparam logic [5:0] SLAVE_ADDR_UPPER = 6'h37;  // Fixed upper six address bits 110111
  localparam int         NUM_REGS         = 24;     // Byte positions 0 through 23
  localparam logic [7:0] NUM_REGS_B       = 8'h18;  // Same count at pointer width
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;   // Bits shifted per byte
  localparam logic [3:0] LAST_BIT         = 4'h7;   // Count value on the last data bit
  localparam logic [3:0] FIRST_TX_BIT     = 4'h1;   // Bit 7 is already driven at load

  // ---------------------------------------------------------------------------
  // Configuration byte layout
  // ---------------------------------------------------------------------------
  localparam int NUM_SETS    = 4;   // Sets picked by the select pins
  localparam int NUM_OUTS    = 6;   // Differential outputs
  localparam int BYP_BASE    = 0;   // One byte per set, bypass in bit 0
  localparam int BYP_BIT     = 0;   // Position of the bypass flag
  localparam int OE_BASE     = 4;   // One byte per set, enables in bits 5:0
  localparam int STYLE_BASE  = 8;   // One byte per set, styles in bits 5:0
  localparam int FREQ_BASE   = 12;  // Three bytes per set, low byte first
  localparam int FREQ_BYTES  = 3;   // Bytes in one frequency word
  localparam int FREQ_W      = 24;  // Width of a frequency word

  // ---------------------------------------------------------------------------
  // APB map
  // ---------------------------------------------------------------------------
  localparam int          PADDR_W      = 12;      // Byte address width
  localparam logic [11:0] OFF_CTRL     = 12'h000; // Control word
  localparam logic [11:0] OFF_STATUS   = 12'h004; // Link status word
  localparam logic [11:0] OFF_WRCNT    = 12'h008; // Bytes written over the link
  localparam logic [11:0] OFF_REGWIN   = 12'h100; // Window onto the 24 bytes
  localparam logic [11:0] OFF_REGEND   = 12'h160; // First address past the window
  localparam int          CTRL_EN_BIT  = 0;       // Link enable bit
  localparam int          ST_BUSY_BIT  = 0;       // Transfer in progress
  localparam int          ST_RW_BIT    = 1;       // Direction of current transfer
  localparam int          ST_PTR_LSB   = 8;       // Pointer field
  localparam int          ST_SEL_LSB   = 16;      // Active set field
  localparam logic        CTRL_EN_RST  = 1'b1;    // Link answers after reset

  // ---------------------------------------------------------------------------
  // Link state machine, one-hot
  // ---------------------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_PTR       = 10'h008,
    ST_PTR_ACK   = 10'h010,
    ST_WDATA     = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA     = 10'h080,
    ST_RACK      = 10'h100,
    ST_IGNORE    = 10'h200
  } ccs_state_t;

  // All state of the block
  typedef struct packed {
    logic [1:0]            scl_sync;   // Clock pin synchroniser
    logic [1:0]            sda_sync;   // Data pin synchroniser
    logic [1:0]            asel_sync;  // Address select synchroniser
    logic [1:0]            sel0_sync;  // Set select bit 0 synchroniser
    logic [1:0]            sel1_sync;  // Set select bit 1 synchroniser
    logic                  scl_prev;   // Last synced clock level
    logic                  sda_prev;   // Last synced data level
    ccs_state_t            state;      // Link phase
    logic [7:0]            shreg;      // Receive shifter
    logic [3:0]            bitcnt;     // Bits in the current byte
    logic                  byte_done;  // Eight bits taken, wait for clock fall
    logic                  rw;         // Read direction latched from address
    logic [7:0]            ptr;        // Register pointer
    logic [7:0]            txbyte;     // Transmit shifter
    logic                  sda_oe;     // Pull data line low
    logic [NUM_REGS*8-1:0] regs;       // Configuration bytes
    logic                  enable;     // Link enable from software
    logic [15:0]           wrcnt;      // Link write counter
    logic [31:0]           prdata;     // APB read data
    logic                  pslverr;    // APB error for the access phase
    logic [NUM_OUTS-1:0]   out_en;     // Active output enables
    logic [NUM_OUTS-1:0]   out_style;  // Active output styles
    logic                  bypass;     // Active bypass flag
    logic [FREQ_W-1:0]     freq;       // Active frequency word
  } ccs_regs_t;

endpackage

/* File: ccs_i2c_host.sv */
// Behavioural serial bus master driving the slave's link pins
`timescale 1ns/1ps
// ----
// Host
// ----
module ccs_i2c_host #(
  parameter int Q = 12  // Quarter of the 48 ns link period
) (
  output logic      scl,     // Link clock, stands high between frames
  output logic      sda_oe,  // Pulls the data line low
  input  wire logic sda      // Resolved data line with pull-up
);
  // Idle: both lines released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop: data rises while clock is high, then a quiet gap
  task automatic stop();
    sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(3*Q);
  endtask
  // One bit out; data moves only while clock is low
  task automatic put(input logic b);
    sda_oe = !b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  // One bit in, sampled in the middle of the high phase
  task automatic get(output logic b);
    sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Byte out, top bit first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(ack);
  endtask
  // Byte in, then our acknowledge or the closing no-acknowledge
  task automatic rbyte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(nack);
  endtask
endmodule

/* File: ccs_config_slave_assertions.sv */
// Port checks on the clock config slave
`timescale 1ns/1ps
// -------
// Checker
// -------
module ccs_link_checker (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        scl_in,
  input wire logic        serial_data_pin_out,
  input wire logic        serial_data_pin_oe,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic hole;  // Address outside the three mapped words and the window range
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Decode of the mapped words
  assign hole = !(paddr == ccs_pkg::OFF_CTRL || paddr == ccs_pkg::OFF_STATUS || paddr == ccs_pkg::OFF_WRCNT
    || (paddr >= ccs_pkg::OFF_REGWIN && paddr < ccs_pkg::OFF_REGEND));
  slave_only_a: assert property (serial_data_pin_out == 1'b0)
    else $error("data pin driven high");
  bit_hold_a: assert property ($changed(serial_data_pin_oe) |=> $stable(serial_data_pin_oe) [*4])
    else $error("data bit too short");
  // Data may only move a few clocks after the link clock fell
  ack_after_fall_a: assert property ($changed(serial_data_pin_oe) |-> !$past(scl_in) && !$past(scl_in, 2)
    && ($past(scl_in, 3) || $past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6)))
    else $error("data moved outside clock low");
  ready_a: assert property (pready)
    else $error("wait state inserted");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  err_hole_a: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == hole)
    else $error("error flag wrong");
  hole_zero_a: assert property (psel && penable && hole |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_stand_a: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved");
endmodule
bind ccs_config_slave ccs_link_checker u_chk (
  .clock(clock), .srst(srst), .scl_in(scl_in), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

/* File: ccs_config_slave_tb_top.sv */
// Self-checking bench for the clock config slave
`timescale 1ns/1ps
module ccs_config_slave_tb_top;
  // -------
  // Signals
  // -------
  logic        clock, srst, scl, hoe, sda, oe, so, asel, psel, penable, pwrite, rdy, err, byp, a, e;
  logic [1:0]  sel;
  logic [5:0]  en, sty;
  logic [23:0] fw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  d;
  logic [7:0]  img [24];  // Expected byte image
  int          mismatches, check_count;
  // Open-drain data line with pull-up
  assign sda = !(hoe || oe);
  ccs_config_slave u_dut (
    .clock(clock), .srst(srst), .scl_in(scl), .serial_data_pin_in(sda), .serial_data_pin_out(so),
    .serial_data_pin_oe(oe), .addr_sel(asel), .config_set_select(sel), .output_enable_bit(en),
    .output_style_bit(sty), .pll_bypass_bit(byp), .freq_word(fw), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(err)
  );
  ccs_i2c_host u_host (.scl(scl), .sda_oe(hoe), .sda(sda));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (rdy !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    // A slave that never answers counts against the run
    if (n >= 100) mismatches++;
    rd = prdata;
    e = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Link byte out with the acknowledge we expect (0 = taken)
  task automatic hw(input logic [7:0] b, input logic x);
    u_host.wbyte(b, a);
    chk("ack", a, x);
  endtask
  // ------
  // Tests
  // ------
  initial begin
    {srst, asel, sel, psel, penable, pwrite, paddr, pwdata} = {1'b1, 50'h0};
    mismatches = 0;
    check_count = 0;
    for (int i = 0; i < 24; i++) img[i] = 8'(i * 29 + 7);
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, ccs_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", rd, {31'h0, ccs_pkg::CTRL_EN_RST});
    apb(1'b0, 12'h00c, 32'h0);
    chk("hole err", e, 1'b1);
    // Block write of all 24 bytes from pointer 0
    u_host.start();
    hw({ccs_pkg::SLAVE_ADDR_UPPER, 2'b00}, 1'b0);
    hw(8'h00, 1'b0);
    for (int i = 0; i < 24; i++) hw(img[i], 1'b0);
    u_host.stop();
    // A whole byte then half a byte before stop
    u_host.start();
    hw({ccs_pkg::SLAVE_ADDR_UPPER, 2'b00}, 1'b0);
    hw(8'h03, 1'b0);
    hw(8'h00, 1'b0);
    for (int i = 0; i < 4; i++) u_host.put(1'b1);
    u_host.stop();
    img[3] = 8'h00;
    // Foreign address is left alone
    @(posedge clock);
    asel <= 1'b1;
    repeat (10) @(posedge clock);
    u_host.start();
    hw({ccs_pkg::SLAVE_ADDR_UPPER, 2'b00}, 1'b1);
    hw(8'h00, 1'b1);
    hw(8'h55, 1'b1);
    u_host.stop();
    // Block read through repeated start at the other address
    u_host.start();
    hw({ccs_pkg::SLAVE_ADDR_UPPER, 2'b10}, 1'b0);
    hw(8'h0a, 1'b0);
    u_host.start();
    hw({ccs_pkg::SLAVE_ADDR_UPPER, 2'b11}, 1'b0);
    for (int i = 10; i < 13; i++) begin
      u_host.rbyte(d, i == 12);
      chk("read", d, img[i]);
    end
    u_host.stop();
    // Register side door, then the full image
    apb(1'b1, ccs_pkg::OFF_REGWIN + 12'h014, 32'h0000_00c3);
    img[5] = 8'hc3;
    for (int i = 0; i < 24; i++) begin
      apb(1'b0, ccs_pkg::OFF_REGWIN + 12'(4 * i), 32'h0);
      chk("image", rd, {24'h0, img[i]});
    end
    // Every set through the select pins
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      sel <= 2'(s);
      repeat (8) @(posedge clock);
      chk("bypass", byp, img[ccs_pkg::BYP_BASE + s][0]);
      chk("enable", en, img[ccs_pkg::OE_BASE + s][5:0]);
      chk("style", sty, img[ccs_pkg::STYLE_BASE + s][5:0]);
      chk("freq", fw, {img[14 + 3 * s], img[13 + 3 * s], img[12 + 3 * s]});
    end
    test_done();
  end
  // Hang guard
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule
